// ---- core/epvc_map.svh ----
// Constants for the slave program/verify controller (host side).
// Assumes a 10 MHz sys_clk; included by the controller module.
`ifndef EPVC_MAP_SVH
`define EPVC_MAP_SVH

//------------------------------------------------------------
// Timing
//------------------------------------------------------------
`define EPVC_CLK_HZ        10000000
`define EPVC_CLK_NS        100
`define EPVC_PGM_MS        10
`define EPVC_PGM_CYC       ((`EPVC_PGM_MS * 1000000) / `EPVC_CLK_NS)
`define EPVC_SETUP_US      2
`define EPVC_SETUP_CYC     ((`EPVC_SETUP_US * 1000 + `EPVC_CLK_NS - 1) / `EPVC_CLK_NS)
`define EPVC_PGM_CS_US     4
`define EPVC_PGM_CS_CYC    ((`EPVC_PGM_CS_US * 1000 + `EPVC_CLK_NS - 1) / `EPVC_CLK_NS)
`define EPVC_CS_DO_NS      400
`define EPVC_CS_DO_CYC     ((`EPVC_CS_DO_NS + `EPVC_CLK_NS - 1) / `EPVC_CLK_NS)
`define EPVC_HIZ_NS        400
`define EPVC_HIZ_CYC       ((`EPVC_HIZ_NS + `EPVC_CLK_NS - 1) / `EPVC_CLK_NS)

//------------------------------------------------------------
// Addresses and data
//------------------------------------------------------------
`define EPVC_MEM_BASE      16'hF800
`define EPVC_MEM_TOP       16'hFFFF
`define EPVC_ERASED        8'hFF
`define EPVC_ADDR_W        11

`endif

// ---- core/epvc_pkg.sv ----
// Types for the slave program/verify controller.
// Assumes nothing beyond a SystemVerilog compiler.
package epvc_pkg;
	typedef enum logic [3:0] {
		EPVC_IDLE,
		EPVC_STRAP,
		EPVC_RUN,
		EPVC_SETUP,
		EPVC_STROBE,
		EPVC_GAP,
		EPVC_SEL,
		EPVC_RELEASE,
		EPVC_DONE
	} epvc_state_e;
endpackage : epvc_pkg

// ---- core/epvc_ctrl.sv ----
// External programmer that drives the device's slave pins.
// Assumes the device pins are sampled synchronous to sys_clk and the
// testbench resolves port C from the enable.
`timescale 1ns/1ps
`include "epvc_map.svh"

module epvc_ctrl
	import epvc_pkg::*;
#(
	parameter int PGM_CYC    = `EPVC_PGM_CYC,
	parameter int SETUP_CYC  = `EPVC_SETUP_CYC,
	parameter int GAP_CYC    = `EPVC_PGM_CS_CYC,
	parameter int READ_CYC   = `EPVC_CS_DO_CYC,
	parameter int HIZ_CYC    = `EPVC_HIZ_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        start_mode,
	input  wire logic        verify_only,
	input  wire logic        req_valid,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_data,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic [7:0]       rsp_data,
	output logic             rsp_match,
	output logic             rsp_range_err,
	output logic             dev_reset_r,
	output logic             mode_select_pin_r,
	output logic             program_strobe_r,
	output logic             select_n_r,
	output logic [2:0]       port_a_addr_r,
	output logic [7:0]       port_d_r,
	output logic [7:0]       port_c_o,
	output logic             port_c_oe_n,
	input  wire logic [7:0]  port_c_i
);

	// Counts are cycles of the 10 MHz sys_clk; the device itself must
	// run from a 2 to 10 MHz clock while it programs
	initial begin
		if (PGM_CYC < 1 || SETUP_CYC < 1 || GAP_CYC < 1 ||
		    READ_CYC < 1 || HIZ_CYC < 1)
			$error("epvc_ctrl: counts must be at least one");
	end

	//------------------------------------------------------------
	// State and datapath registers
	//------------------------------------------------------------
	epvc_state_e  state_r, state_nxt;
	logic [31:0]  cnt_r, cnt_nxt;
	logic         verify_r;
	logic         erase_r;
	logic         sel_end_r;
	logic [7:0]   wdata_r;
	logic         req_ready_r, rsp_valid_r, rsp_match_r, rsp_err_r;
	logic [7:0]   rsp_data_r;
	logic [7:0]   port_c_o_r;
	logic         port_c_oe_n_r;

	// Range check used by acceptance and the error answer
	function automatic logic epvc_in_range(input logic [15:0] a);
		return a >= `EPVC_MEM_BASE;
	endfunction : epvc_in_range

	wire cnt_done   = (cnt_r == 32'h0000_0001);
	wire take_req   = (state_r == EPVC_RUN) && req_valid;
	wire req_ok     = epvc_in_range(req_addr);
	wire read_match = (port_c_i == wdata_r);

	//------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------
	// Reset strap chooses program or verify mode; software never
	// switches modes afterwards, only a new strap cycle does
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = (cnt_r > 32'h0) ? cnt_r - 32'h1 : 32'h0;
		case (state_r)
			EPVC_IDLE: begin
				if (start_mode) begin
					state_nxt = EPVC_STRAP;
					cnt_nxt   = SETUP_CYC;
				end
			end
			EPVC_STRAP: begin
				if (cnt_done)
					state_nxt = EPVC_RUN;
			end
			EPVC_RUN: begin
				if (take_req && req_ok) begin
					state_nxt = EPVC_SETUP;
					cnt_nxt   = SETUP_CYC;
				end
			end
			EPVC_SETUP: begin
				if (cnt_done) begin
					state_nxt = EPVC_STROBE;
					cnt_nxt   = PGM_CYC;
				end
			end
			EPVC_STROBE: begin
				if (cnt_done) begin
					state_nxt = EPVC_GAP;
					cnt_nxt   = GAP_CYC;
				end
			end
			// After the ones pass, program again with the real byte
			EPVC_GAP: begin
				if (cnt_done && erase_r) begin
					state_nxt = EPVC_SETUP;
					cnt_nxt   = SETUP_CYC;
				end else if (cnt_done) begin
					state_nxt = EPVC_SEL;
					cnt_nxt   = READ_CYC;
				end
			end
			EPVC_SEL: begin
				if (cnt_done) begin
					state_nxt = EPVC_RELEASE;
					cnt_nxt   = HIZ_CYC;
				end
			end
			EPVC_RELEASE: begin
				if (cnt_done)
					state_nxt = EPVC_RUN;
			end
			default: begin
				state_nxt = EPVC_IDLE;
			end
		endcase
	end

	// Pin levels decoded from the state
	wire in_strap  = (state_r == EPVC_STRAP) || (state_r == EPVC_IDLE);
	wire strobe_hi = (state_r == EPVC_STROBE);
	wire sel_lo    = (state_r == EPVC_SEL);
	wire drive_c   = !verify_r && ((state_r == EPVC_SETUP) ||
		(state_r == EPVC_STROBE) || (state_r == EPVC_GAP));
	// In strap, bit seven high and bit four high selects program,
	// low selects verify
	wire strobe_lvl = in_strap ? 1'b1 : strobe_hi;
	wire sel_lvl    = in_strap ? !verify_r : !sel_lo;
	// First pass of a program request puts all ones on port C
	wire [7:0] c_wdata = erase_r ? `EPVC_ERASED : wdata_r;

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= EPVC_IDLE;
			cnt_r   <= 32'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// Mode latched at start; address and data held for whole cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			verify_r      <= 1'b0;
			wdata_r       <= `EPVC_ERASED;
			erase_r       <= 1'b0;
			port_a_addr_r <= 3'h0;
			port_d_r      <= 8'h00;
		end else begin
			if (state_r == EPVC_IDLE && start_mode)
				verify_r <= verify_only;
			if (take_req && req_ok) begin
				port_d_r      <= req_addr[7:0];
				port_a_addr_r <= req_addr[10:8];
				wdata_r       <= req_data;
				erase_r       <= !verify_r;
			end else if (state_r == EPVC_GAP && cnt_done) begin
				erase_r       <= 1'b0;
			end
		end
	end

	// Pin drivers, all straight from flip-flops
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dev_reset_r       <= 1'b1;
			mode_select_pin_r <= 1'b0;
			program_strobe_r  <= 1'b0;
			select_n_r        <= 1'b1;
			port_c_o_r        <= 8'h00;
			port_c_oe_n_r     <= 1'b1;
		end else begin
			dev_reset_r       <= (state_nxt == EPVC_IDLE) ||
				(state_nxt == EPVC_STRAP);
			mode_select_pin_r <= (state_nxt != EPVC_IDLE);
			program_strobe_r  <= strobe_lvl;
			select_n_r        <= sel_lvl;
			port_c_o_r        <= c_wdata;
			port_c_oe_n_r     <= !drive_c;
		end
	end

	// Answer taken one edge after the last select cycle: the select pin
	// trails the state by a cycle, so the byte has stood READ_CYC cycles
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			req_ready_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 8'h00;
			rsp_match_r <= 1'b0;
			rsp_err_r   <= 1'b0;
			sel_end_r   <= 1'b0;
		end else begin
			req_ready_r <= (state_nxt == EPVC_RUN) && !take_req;
			sel_end_r   <= sel_lo && cnt_done;
			rsp_valid_r <= sel_end_r || (take_req && !req_ok);
			rsp_err_r   <= take_req && !req_ok;
			if (sel_end_r) begin
				rsp_data_r  <= port_c_i;
				rsp_match_r <= read_match;
			end
		end
	end

	assign req_ready     = req_ready_r;
	assign rsp_valid     = rsp_valid_r;
	assign rsp_data      = rsp_data_r;
	assign rsp_match     = rsp_match_r;
	assign rsp_range_err = rsp_err_r;
	assign port_c_o      = port_c_o_r;
	assign port_c_oe_n   = port_c_oe_n_r;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	property p_no_c_during_sel;
		@(posedge sys_clk) disable iff (reset)
		!select_n_r |-> port_c_oe_n;
	endproperty
	a_no_c_during_sel: assert property (p_no_c_during_sel)
		else $error("port C driven while select low");

	property p_strobe_sel_excl;
		@(posedge sys_clk) disable iff (reset)
		(!dev_reset_r && !$past(dev_reset_r) && program_strobe_r) |->
			select_n_r;
	endproperty
	a_strobe_sel_excl: assert property (p_strobe_sel_excl)
		else $error("strobe high with select low");

	property p_sel_after_strobe;
		@(posedge sys_clk) disable iff (reset)
		$fell(select_n_r) && !dev_reset_r |-> !program_strobe_r;
	endproperty
	a_sel_after_strobe: assert property (p_sel_after_strobe)
		else $error("select fell with strobe high");

	property p_strap_mode;
		@(posedge sys_clk) disable iff (reset)
		$fell(dev_reset_r) |-> mode_select_pin_r && program_strobe_r
			&& (select_n_r == !verify_r);
	endproperty
	a_strap_mode: assert property (p_strap_mode)
		else $error("bad strap at reset release");

	property p_verify_strap;
		@(posedge sys_clk) disable iff (reset)
		$fell(dev_reset_r) && verify_r |-> !select_n_r;
	endproperty
	a_verify_strap: assert property (p_verify_strap)
		else $error("verify strap select not low");

	property p_addr_stable;
		@(posedge sys_clk) disable iff (reset)
		program_strobe_r && !dev_reset_r |->
			$stable(port_d_r) && $stable(port_a_addr_r);
	endproperty
	a_addr_stable: assert property (p_addr_stable)
		else $error("address moved during strobe");

	property p_verify_no_drive;
		@(posedge sys_clk) disable iff (reset)
		verify_r |-> port_c_oe_n;
	endproperty
	a_verify_no_drive: assert property (p_verify_no_drive)
		else $error("port C driven in verify mode");

	property p_range_err;
		@(posedge sys_clk) disable iff (reset)
		take_req && !req_ok |=> rsp_valid && rsp_range_err;
	endproperty
	a_range_err: assert property (p_range_err)
		else $error("out of range not refused");

	property p_strobe_pulse;
		@(posedge sys_clk) disable iff (reset)
		$rose(program_strobe_r) && !dev_reset_r |-> ##1 program_strobe_r;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse)
		else $error("strobe pulse too short");

	// A program request always opens with an all-ones pass on port C
	property p_erase_first;
		@(posedge sys_clk) disable iff (reset)
		$rose(program_strobe_r) && !dev_reset_r && erase_r |->
			!port_c_oe_n && (port_c_o == `EPVC_ERASED);
	endproperty
	a_erase_first: assert property (p_erase_first)
		else $error("program pass without ones pass first");

	c_program: cover property (@(posedge sys_clk) disable iff (reset)
		rsp_valid && !verify_r && rsp_match);
	c_verify: cover property (@(posedge sys_clk) disable iff (reset)
		rsp_valid && verify_r);
	c_range: cover property (@(posedge sys_clk) disable iff (reset)
		rsp_valid && rsp_range_err);
	c_erase: cover property (@(posedge sys_clk) disable iff (reset)
		$fell(erase_r) && !verify_r);

endmodule : epvc_ctrl

// ---- sim/epvc_dev_model.sv ----
// Behavioural model of the device's slave program/verify pins.
// Assumes pins change just after sys_clk edges; resolves port C.
`timescale 1ns/1ps

module epvc_dev_model (
	input  wire logic       sys_clk,
	input  wire logic       dev_rst,
	input  wire logic       mode_select_pin,
	input  wire logic       program_strobe,
	input  wire logic       select_n,
	input  wire logic [2:0] a_hi,
	input  wire logic [7:0] a_lo,
	input  wire logic [7:0] h_c,
	input  wire logic       h_oe_n,
	output logic      [7:0] c_bus
);
	logic [7:0]  mem [0:2047];
	logic [10:0] addr_r;
	logic [1:0]  mode_r;
	logic        rst_q, stb_q, armed_r, clash;
	logic [7:0]  last_r;
	wire logic   drv = (mode_r != 2'h0) && !program_strobe && !select_n;

	//--------------------------------------------------------
	// Memory starts erased; modes known only after a strap
	//--------------------------------------------------------
	initial begin
		for (int i = 0; i < 2048; i++)
			mem[i] = 8'hFF;
		{rst_q, stb_q, armed_r, clash, mode_r} = 6'h20;
		last_r = 8'h00;
	end

	// Mode is taken only at the reset release edge
	// Mode then holds until the next strap, as a locked mode would
	always @(posedge sys_clk) begin
		rst_q <= dev_rst;
		stb_q <= program_strobe;
		if (dev_rst)
			mode_r <= 2'h0;
		else if (rst_q)
			mode_r <= !(mode_select_pin && program_strobe) ? 2'h0 :
				select_n ? 2'h1 : 2'h2;
		// Strobe rise latches the offset in F800-FFFF
		if (!dev_rst && mode_r != 2'h0 && program_strobe && !stb_q) begin
			addr_r <= {a_hi, a_lo};
			armed_r <= select_n;
		end
		// Write at strobe fall so data is held all pulse
		if (!program_strobe && stb_q && armed_r && mode_r == 2'h1) begin
			// All ones restores the byte; otherwise bits only clear
			mem[addr_r] <= (c_bus == 8'hFF) ? 8'hFF :
				mem[addr_r] & c_bus;
			armed_r <= 1'b0;
		end
		if (drv && !h_oe_n)
			clash <= 1'b1;
		if (!h_oe_n || drv)
			last_r <= c_bus;
	end

	// Undriven port C shows the inverse of the last driven byte
	assign c_bus = !h_oe_n ? h_c : drv ? mem[addr_r] : ~last_r;
endmodule : epvc_dev_model

// ---- sim/eeprom_program_verify_ctrl_tb_top.sv ----
// Self-checking bench for the slave program/verify controller.
// Assumes epvc_dev_model stands on the device pins.
`timescale 1ns/1ps

module eeprom_program_verify_ctrl_tb_top;
	logic       sys_clk, reset, start_mode, verify_only, req_valid;
	logic [15:0] req_addr;
	logic [7:0] req_data, rsp_data, port_d_r, port_c_o, c_bus;
	logic       req_ready, rsp_valid, rsp_match, rsp_range_err;
	logic       dev_reset_r, mode_select_pin_r, program_strobe_r;
	logic       select_n_r, port_c_oe_n;
	logic [2:0] port_a_addr_r;
	int         fails, tests_run;

	//--------------------------------------------------------
	// Design, device model and clock
	//--------------------------------------------------------
	epvc_ctrl #(.PGM_CYC(20), .SETUP_CYC(3), .GAP_CYC(3),
		.READ_CYC(3), .HIZ_CYC(3)) u_dut (.sys_clk, .reset,
		.start_mode, .verify_only, .req_valid, .req_addr, .req_data,
		.req_ready, .rsp_valid, .rsp_data, .rsp_match, .rsp_range_err,
		.dev_reset_r, .mode_select_pin_r, .program_strobe_r,
		.select_n_r, .port_a_addr_r, .port_d_r, .port_c_o,
		.port_c_oe_n, .port_c_i(c_bus));
	epvc_dev_model u_dev (.sys_clk, .dev_rst(dev_reset_r),
		.mode_select_pin(mode_select_pin_r),
		.program_strobe(program_strobe_r), .select_n(select_n_r),
		.a_hi(port_a_addr_r), .a_lo(port_d_r), .h_c(port_c_o),
		.h_oe_n(port_c_oe_n), .c_bus);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	//--------------------------------------------------------
	// Shared tasks
	//--------------------------------------------------------
	task automatic check(input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	// Bounded wait; sampled mid-cycle so registered outputs are settled
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (s !== 1'b1 && n < 200);
		if (s !== 1'b1) begin
			fails++;
			end_sim();
		end
	endtask : wait_hi

	// Reset for two cycles, then strap the wanted slave mode
	task automatic start(input logic v);
		@(posedge sys_clk);
		reset <= 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		check({dev_reset_r, mode_select_pin_r, program_strobe_r, select_n_r,
			port_c_oe_n, req_ready, rsp_valid}, 16'h004C);
		@(posedge sys_clk);
		reset <= 1'b0;
		verify_only <= v;
		start_mode <= 1'b1;
		@(posedge sys_clk);
		start_mode <= 1'b0;
		wait_hi(req_ready);
		// The device takes its strap one edge after the release
		@(negedge sys_clk);
		check(u_dev.mode_r, v ? 16'h2 : 16'h1);
	endtask : start

	// One request held until taken, then its answer judged
	task automatic xfer(input logic [15:0] a, input logic [7:0] d, x,
		input logic m, e);
		@(posedge sys_clk);
		req_addr <= a;
		req_data <= d;
		req_valid <= 1'b1;
		wait_hi(req_ready);
		@(posedge sys_clk);
		req_valid <= 1'b0;
		wait_hi(rsp_valid);
		check(rsp_range_err, e);
		if (!e) begin
			check(rsp_data, x);
			check(rsp_match, m);
			check(u_dev.addr_r, a[10:0]);
			check({port_a_addr_r, port_d_r}, a[10:0]);
		end
	endtask : xfer

	//--------------------------------------------------------
	// Scenarios
	//--------------------------------------------------------
	task automatic sc_program;
		start(1'b0);
		xfer(16'hF800, 8'hA5, 8'hA5, 1'b1, 1'b0);
		check(u_dev.mem[0], 8'hA5);
		xfer(16'hFFFF, 8'h3C, 8'h3C, 1'b1, 1'b0);
		check(u_dev.mem[2047], 8'h3C);
	endtask : sc_program

	// Below the window is refused; a reprogram restores ones first
	task automatic sc_edges;
		xfer(16'hF7FF, 8'h00, 8'h00, 1'b0, 1'b1);
		xfer(16'hFFFF, 8'hC3, 8'hC3, 1'b1, 1'b0);
		check(u_dev.mem[2047], 8'hC3);
	endtask : sc_edges

	// Verify mode reads back and never writes
	task automatic sc_verify;
		start(1'b1);
		xfer(16'hF800, 8'hA5, 8'hA5, 1'b1, 1'b0);
		xfer(16'hF800, 8'h5A, 8'hA5, 1'b0, 1'b0);
		check(u_dev.mem[0], 8'hA5);
		check(u_dev.clash, 1'b0);
	endtask : sc_verify

	initial begin
		reset = 1'b1;
		start_mode = 1'b0;
		verify_only = 1'b0;
		req_valid = 1'b0;
		req_addr = 16'h0000;
		req_data = 8'h00;
		fails = 0;
		tests_run = 0;
		sc_program();
		sc_edges();
		sc_verify();
		end_sim();
	end
endmodule : eeprom_program_verify_ctrl_tb_top
